// File: common/flags_map.vh
// register offsets, field positions, reset values and op codes for
// the condition flags block; included by every design file of the block.
// How it works
// - eight-bit flags register, readable, writable, stackable
// - half carry from bit three on adds
// - negative flag copies result bit seven
// - zero flag set when result is zero
// - carry flag shows overflow or borrow
// - set, reset, shift, rotate, bit-test drive carry
// - branch conditions decoded from the h, n, z and c flags
// - priority bits five and three encode level
// - interrupt entry loads priority from source registers
// - enable, disable, return, halt, wait, pop modify priority
// - halt forces priority pattern to level zero
`ifndef FLAGS_MAP_VH
`define FLAGS_MAP_VH
`define FLAGS_ADDR_FLAGS 12'h000
`define FLAGS_ADDR_STATUS 12'h004
`define FLAGS_ADDR_RESULT 12'h008
`define FLAGS_BIT_C 0
`define FLAGS_BIT_Z 1
`define FLAGS_BIT_N 2
`define FLAGS_BIT_PL 3
`define FLAGS_BIT_H 4
`define FLAGS_BIT_PU 5
`define FLAGS_RESET 8'hE8
`define FLAGS_FIXED_ONES 8'hC0
`define PRIO_LEVEL0 2'b10
`define PRIO_LEVEL1 2'b01
`define PRIO_LEVEL2 2'b00
`define PRIO_LEVEL3 2'b11
`define OP_NONE 4'h0
`define OP_ADD 4'h1
`define OP_ADC 4'h2
`define OP_SUB 4'h3
`define OP_LOGIC 4'h4
`define OP_SCF 4'h5
`define OP_RCF 4'h6
`define OP_SHIFT 4'h7
`define OP_BTJ 4'h8
`define OP_RIM 4'h9
`define OP_SIM 4'hA
`define OP_IRET 4'hB
`define OP_HALT 4'hC
`define OP_WFI 4'hD
`define OP_POP 4'hE
`define OP_IRQ 4'hF
`endif

// File: hw/flags_cond.v
// branch condition decoder: picks one flag test out of eight
// assumes the flags byte comes from the register in the same clock domain
`include "flags_map.vh"
`default_nettype none
module flags_cond (
  input wire [7:0] flags_i,
  input wire [2:0] sel_i,
  output reg take_o
);
  always @* begin
    case (sel_i[2:1])
      2'd0: take_o = flags_i[`FLAGS_BIT_H];
      2'd1: take_o = flags_i[`FLAGS_BIT_N];
      2'd2: take_o = flags_i[`FLAGS_BIT_Z];
      2'd3: take_o = flags_i[`FLAGS_BIT_C];
      default: take_o = 1'b0;
    endcase
    // odd selects test the flag clear (jrnh, jrpl, jrne, jrnc)
    if (sel_i[0]) begin
      take_o = ~take_o;
    end
  end
endmodule
`default_nettype wire

// File: hw/condition_flags_register.v
// condition flags register of the 8-bit core, with an ahb-lite window
// assumes single-clock core; the decoder presents one op per cycle
`include "flags_map.vh"
`default_nettype none
module condition_flags_register (
  input wire CORE_CLK_I,
  input wire RST_I,
  // ahb-lite slave
  input wire HSEL_I,
  input wire [11:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire [2:0] HSIZE_I,
  input wire [31:0] HWDATA_I,
  input wire HREADY_I,
  output reg [31:0] HRDATA_O,
  output reg HREADYOUT_O,
  output reg HRESP_O,
  // core datapath side
  input wire [3:0] OP_I,
  input wire [7:0] OPA_I,
  input wire [7:0] OPB_I,
  input wire [7:0] LOGIC_RES_I,
  input wire SHIFT_C_I,
  input wire [1:0] SRC_PRIO_I,
  input wire [7:0] POP_DATA_I,
  input wire [2:0] COND_SEL_I,
  output reg [7:0] FLAGS_O,
  output reg [7:0] RESULT_O,
  output reg BRANCH_O,
  output reg INT_OFF_O
);
  reg [7:0] flags_ff; // live flags byte
  reg [7:0] nxt_flags;
  reg [7:0] result_ff; // last alu result
  reg [7:0] nxt_result;
  reg [8:0] sum; // widened alu sum
  reg [4:0] low_sum; // low nibble sum for half carry
  reg res_valid; // op yields a result
  reg wr_pend_ff; // write data phase pending
  reg [11:0] addr_ff; // latched address
  reg rd_pend_ff; // read data phase pending
  wire take; // branch decision
  wire cpu_busy; // core owns the register this cycle
  assign cpu_busy = (OP_I != `OP_NONE);

  flags_cond u_cond (
    .flags_i(flags_ff),
    .sel_i(COND_SEL_I),
    .take_o(take)
  );

  // next flags from the datapath op
  always @* begin
    nxt_flags = flags_ff;
    nxt_result = result_ff;
    res_valid = 1'b0;
    sum = 9'h000;
    low_sum = 5'h00;
    case (OP_I)
      `OP_ADD, `OP_ADC: begin
        low_sum = {1'b0, OPA_I[3:0]} + {1'b0, OPB_I[3:0]} +
          {4'h0, (OP_I == `OP_ADC) & flags_ff[`FLAGS_BIT_C]};
        sum = {1'b0, OPA_I} + {1'b0, OPB_I} +
          {8'h00, (OP_I == `OP_ADC) & flags_ff[`FLAGS_BIT_C]};
        nxt_flags[`FLAGS_BIT_H] = low_sum[4];
        nxt_flags[`FLAGS_BIT_C] = sum[8];
        nxt_result = sum[7:0];
        res_valid = 1'b1;
      end
      `OP_SUB: begin
        sum = {1'b0, OPA_I} - {1'b0, OPB_I};
        nxt_flags[`FLAGS_BIT_C] = sum[8];
        nxt_result = sum[7:0];
        res_valid = 1'b1;
      end
      `OP_LOGIC: begin
        nxt_result = LOGIC_RES_I;
        res_valid = 1'b1;
      end
      `OP_SCF: nxt_flags[`FLAGS_BIT_C] = 1'b1;
      `OP_RCF: nxt_flags[`FLAGS_BIT_C] = 1'b0;
      `OP_SHIFT: begin
        nxt_flags[`FLAGS_BIT_C] = SHIFT_C_I;
        nxt_result = LOGIC_RES_I;
        res_valid = 1'b1;
      end
      `OP_BTJ: nxt_flags[`FLAGS_BIT_C] = SHIFT_C_I;
      `OP_RIM: {nxt_flags[`FLAGS_BIT_PU], nxt_flags[`FLAGS_BIT_PL]} =
        `PRIO_LEVEL0;
      `OP_SIM: {nxt_flags[`FLAGS_BIT_PU], nxt_flags[`FLAGS_BIT_PL]} =
        `PRIO_LEVEL3;
      `OP_IRET, `OP_POP: nxt_flags = POP_DATA_I;
      `OP_HALT, `OP_WFI: {nxt_flags[`FLAGS_BIT_PU],
        nxt_flags[`FLAGS_BIT_PL]} = `PRIO_LEVEL0;
      `OP_IRQ: {nxt_flags[`FLAGS_BIT_PU], nxt_flags[`FLAGS_BIT_PL]} =
        SRC_PRIO_I;
      default: nxt_flags = flags_ff;
    endcase
    if (res_valid) begin
      nxt_flags[`FLAGS_BIT_N] = nxt_result[7];
      nxt_flags[`FLAGS_BIT_Z] = (nxt_result == 8'h00);
    end
    // software write, dropped if the core updates too
    // folded in here so the flags copy, read data and level agree
    if (wr_pend_ff && addr_ff == `FLAGS_ADDR_FLAGS && !cpu_busy) begin
      nxt_flags = HWDATA_I[7:0];
    end
    nxt_flags = nxt_flags | `FLAGS_FIXED_ONES;
  end

  // flags, result and bus state; the core wins over a bus write
  always @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      flags_ff <= `FLAGS_RESET;
      result_ff <= 8'h00;
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 12'h000;
      HRDATA_O <= 32'h0000_0000;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      FLAGS_O <= `FLAGS_RESET;
      RESULT_O <= 8'h00;
      BRANCH_O <= 1'b0;
      INT_OFF_O <= 1'b1;
    end else begin
      flags_ff <= nxt_flags;
      result_ff <= nxt_result;
      // address phase capture
      if (HSEL_I && HREADY_I && HTRANS_I[1]) begin
        wr_pend_ff <= HWRITE_I;
        rd_pend_ff <= ~HWRITE_I;
        addr_ff <= HADDR_I;
      end else if (HREADY_I) begin
        wr_pend_ff <= 1'b0;
        rd_pend_ff <= 1'b0;
      end
      // read data for the next data phase
      if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I) begin
        case (HADDR_I)
          `FLAGS_ADDR_FLAGS: HRDATA_O <= {24'h00_0000, nxt_flags};
          `FLAGS_ADDR_STATUS: HRDATA_O <= {31'h0000_0000, take};
          `FLAGS_ADDR_RESULT: HRDATA_O <= {24'h00_0000, nxt_result};
          default: HRDATA_O <= 32'h0000_0000;
        endcase
      end
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      FLAGS_O <= nxt_flags;
      RESULT_O <= nxt_result;
      BRANCH_O <= take;
      INT_OFF_O <= nxt_flags[`FLAGS_BIT_PU] & nxt_flags[`FLAGS_BIT_PL];
    end
  end
endmodule
`default_nettype wire

// File: testbench/flags_props.sv
// port checker for the condition flags register
// assumes one core clock and the op codes of the shared map
`include "flags_map.vh"
`default_nettype none
module flags_props (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] OP_I,
  input wire logic [7:0] OPA_I,
  input wire logic [7:0] OPB_I,
  input wire logic [1:0] SRC_PRIO_I,
  input wire logic [2:0] COND_SEL_I,
  input wire logic [7:0] FLAGS_O,
  input wire logic [7:0] RESULT_O,
  input wire logic BRANCH_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);
  // low nibble and full sums of the adder operands
  wire [4:0] lo = OPA_I[3:0] + OPB_I[3:0];
  wire [8:0] sm = OPA_I + OPB_I;
  // flag picked by the select: h, n, z, c in select order
  wire [3:0] fv = {FLAGS_O[0], FLAGS_O[1], FLAGS_O[2], FLAGS_O[4]};
  wire want = fv[COND_SEL_I[2:1]] ^ COND_SEL_I[0];
  AST_ONES: assert property (FLAGS_O[7:6] == 2'b11)
    else $error("flags top bits not one");
  AST_ADD_H: assert property (OP_I == `OP_ADD |=>
    FLAGS_O[4] == $past(lo[4])) else $error("half carry wrong");
  AST_ADD_C: assert property (OP_I == `OP_ADD |=>
    FLAGS_O[0] == $past(sm[8])) else $error("carry wrong");
  AST_ADD_NZ: assert property (OP_I == `OP_ADD |=>
    RESULT_O == $past(sm[7:0]) && FLAGS_O[2] == RESULT_O[7]
    && FLAGS_O[1] == (RESULT_O == 8'h00)) else $error("n or z wrong");
  AST_CARRY_SR: assert property (
    OP_I == `OP_SCF || OP_I == `OP_RCF |=>
    FLAGS_O[0] == $past(OP_I == `OP_SCF)) else $error("scf rcf wrong");
  AST_IRQ: assert property (OP_I == `OP_IRQ |=>
    {FLAGS_O[5], FLAGS_O[3]} == $past(SRC_PRIO_I))
    else $error("irq priority wrong");
  AST_HALT: assert property (OP_I == `OP_HALT |=>
    {FLAGS_O[5], FLAGS_O[3]} == 2'b10) else $error("halt level wrong");
  AST_BRANCH: assert property (1'b1 |=> BRANCH_O == $past(want))
    else $error("branch decision wrong");
  cover property (OP_I == `OP_ADD);
  cover property (OP_I == `OP_HALT);
  cover property (OP_I == `OP_IRQ);
endmodule
bind condition_flags_register flags_props u_props (.CORE_CLK_I, .RST_I,
  .OP_I, .OPA_I, .OPB_I, .SRC_PRIO_I, .COND_SEL_I, .FLAGS_O, .RESULT_O,
  .BRANCH_O);
`default_nettype wire

// File: testbench/tb.sv
// bench for the condition flags register: bus and op port tests
// assumes a zero wait state slave and one op per cycle
`include "flags_map.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, hsel = 0, hwr = 0, shc = 0, rdy, hresp, br, ioff;
  logic [1:0] htr = 0, spr = 0;
  logic [11:0] hadr = 0;
  logic [31:0] hwd = 0, hrd;
  logic [7:0] opa = 0, opb = 0, lres = 0, pop = 8'h15, flg, res;
  logic [3:0] op = 0;
  logic [2:0] csel = 0;
  int failures = 0, check_count = 0, cyc = 0;
  // the slave's own ready is the bus ready
  condition_flags_register dut (.CORE_CLK_I(clk), .RST_I(rst),
    .HSEL_I(hsel), .HADDR_I(hadr), .HTRANS_I(htr), .HWRITE_I(hwr),
    .HSIZE_I(3'b010), .HWDATA_I(hwd), .HREADY_I(rdy), .HRDATA_O(hrd),
    .HREADYOUT_O(rdy), .HRESP_O(hresp), .OP_I(op), .OPA_I(opa),
    .OPB_I(opb), .LOGIC_RES_I(lres), .SHIFT_C_I(shc), .SRC_PRIO_I(spr),
    .POP_DATA_I(pop), .COND_SEL_I(csel), .FLAGS_O(flg), .RESULT_O(res),
    .BRANCH_O(br), .INT_OFF_O(ioff));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // hang guard: the tests need about seventy cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // single word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    hsel <= 1;
    htr <= 2'b10;
    hwr <= w;
    hadr <= a;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    htr <= 2'b00;
    hwd <= d;
    @(posedge clk);
    while (rdy !== 1'b1) @(posedge clk);
    q = hrd;
  endtask
  // one op cycle, then the flags are compared once they have settled
  task automatic do_op(input logic [3:0] c, input logic [7:0] a, b, e);
    op <= c;
    opa <= a;
    opb <= b;
    @(posedge clk);
    op <= `OP_NONE;
    @(posedge clk);
    chk("flags", e, flg);
  endtask
  initial begin
    logic [31:0] q;
    logic [7:0] bx;
    bx = 8'h59;
    repeat (10) @(posedge clk);
    rst <= 0;
    bus(0, `FLAGS_ADDR_FLAGS, 0, q);
    chk("rd_reset", 32'h0000_00E8, q);
    chk("int_off", 1, ioff);
    chk("hresp", 0, hresp);
    chk("hready", 1, rdy);
    bus(1, `FLAGS_ADDR_FLAGS, 32'h0000_0000, q);
    bus(0, `FLAGS_ADDR_FLAGS, 0, q);
    chk("rd_write", 32'h0000_00C0, q);
    bus(0, 12'h010, 0, q);
    chk("rd_unmapped", 0, q);
    $display("test bus done");
    do_op(`OP_ADD, 8'h0F, 8'hF1, 8'hD3);
    chk("result", 0, res);
    for (int i = 0; i < 8; i++) begin
      csel <= i[2:0];
      repeat (2) @(posedge clk);
      chk("branch", bx[i], br);
    end
    $display("test branch done");
    do_op(`OP_ADD, 8'h70, 8'h18, 8'hC4);
    do_op(`OP_SUB, 8'h00, 8'h01, 8'hC5);
    chk("result", 8'hFF, res);
    do_op(`OP_RCF, 0, 0, 8'hC4);
    do_op(`OP_SCF, 0, 0, 8'hC5);
    $display("test arith done");
    spr <= 2'b01;
    do_op(`OP_IRQ, 0, 0, 8'hCD);
    do_op(`OP_HALT, 0, 0, 8'hE5);
    do_op(`OP_POP, 0, 0, 8'hD5);
    do_op(`OP_SIM, 0, 0, 8'hFD);
    @(posedge clk);
    chk("int_off", 1, ioff);
    do_op(`OP_WFI, 0, 0, 8'hF5);
    do_op(`OP_SIM, 0, 0, 8'hFD);
    do_op(`OP_RIM, 0, 0, 8'hF5);
    $display("test priority done");
    do_op(`OP_ADC, 8'h07, 8'h08, 8'hF0);
    lres <= 8'h80;
    shc <= 1;
    do_op(`OP_SHIFT, 0, 0, 8'hF5);
    chk("result", 8'h80, res);
    shc <= 0;
    do_op(`OP_BTJ, 0, 0, 8'hF4);
    lres <= 8'h00;
    do_op(`OP_LOGIC, 0, 0, 8'hF2);
    do_op(`OP_IRET, 0, 0, 8'hD5);
    $display("test ops done");
    close_out();
  end
endmodule
`default_nettype wire
